//--- logic/hpp_port.sv
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "hpp_cfg.svh"
module hpp_port
  import hpp_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic  [7:0] i_pa_in,      // first_data_port pins in
  output logic       [7:0] o_pa_out,
  output logic       [7:0] o_pa_oe_n,    // Low while driving
  input  wire logic  [7:0] i_pb_in,      // second_data_port pins in
  output logic       [7:0] o_pb_out,
  output logic       [7:0] o_pb_oe_n,
  input  wire logic  [7:0] i_pc_in,      // handshake_port_lines in
  output logic       [7:0] o_pc_out,
  output logic       [7:0] o_pc_oe_n,
  output logic             o_irq         // Level interrupt
);
  // ----------------------------------------
  // Reset synchroniser
  // ----------------------------------------
  logic rst_meta_ff;  // First stage, read only by second
  logic rst_sync_ff;  // Released reset used everywhere
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  wire logic rst_n = rst_sync_ff;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  hpp_mode_type             mode_ff;   // Port C mode
  logic [7:0]               pa_ff;     // Port A output latch
  logic [7:0]               pb_ff;     // Port B output latch
  logic [7:0]               pc_ff;     // Port C plain output bits
  logic [3:0]               dir_ff;    // 1=out: A, B, C low, C high
  logic [1:0]               ien_ff;    // Service enable A, B
  logic [`HPP_NUM_EV-1:0]   stat_ff;   // Sticky events
  logic [`HPP_NUM_EV-1:0]   imask_ff;  // Interrupt mask
  hpp_apb_req_type          req;
  assign req = '{i_psel, i_penable, i_pwrite, i_paddr, i_pwdata};

  // Decode used by write and read paths
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  wire logic acc = req.psel && req.penable;
  wire logic wr  = acc && req.pwrite;
  wire logic rd  = acc && !req.pwrite;

  // Group wiring
  logic       a_in_en, a_out_en, b_in_en, b_out_en;
  logic       a_stb_n, a_ack_n, b_stb_n, b_ack_n;
  logic [7:0] a_data, b_data;
  logic       a_ibf, a_obf_n, b_ibf, b_obf_n;
  logic       a_ev_in, a_ev_out, b_ev_in, b_ev_out;
  logic       a_rd, a_wr, b_rd, b_wr;
  logic       service_request_a, service_request_b;
  logic [7:0] hs_mask;   // 1 where port C line is a handshake role

  // Mode register write
  // All four encodings are modes, so no mode write is refused
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= HPP_MODE0;
    end else if (wr && hit(req.paddr, `HPP_OFF_MODE)) begin
      mode_ff <= hpp_mode_type'(req.pwdata[`HPP_MODE_W-1:0]);
    end
  end

  // Data and direction registers
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pa_ff  <= 8'h00;
      pb_ff  <= 8'h00;
      pc_ff  <= 8'h00;
      dir_ff <= `HPP_DIR_RST;
      ien_ff <= 2'h0;
    end else if (wr) begin
      if (hit(req.paddr, `HPP_OFF_PA)) begin
        pa_ff <= req.pwdata[7:0];
      end else if (hit(req.paddr, `HPP_OFF_PB)) begin
        pb_ff <= req.pwdata[7:0];
      end else if (hit(req.paddr, `HPP_OFF_PC)) begin
        pc_ff <= req.pwdata[7:0];
      end else if (hit(req.paddr, `HPP_OFF_DIR)) begin
        dir_ff <= req.pwdata[3:0];
      end else if (hit(req.paddr, `HPP_OFF_IEN)) begin
        ien_ff <= req.pwdata[1:0];
      end
    end
  end

  // Mask register
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      imask_ff <= 4'h0;
    end else if (wr && hit(req.paddr, `HPP_OFF_IMASK)) begin
      imask_ff <= req.pwdata[`HPP_NUM_EV-1:0];
    end
  end

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  // Group B has no handshake in mode 2; it falls back to plain I/O
  always_comb begin
    a_in_en  = 1'b0;
    a_out_en = 1'b0;
    b_in_en  = 1'b0;
    b_out_en = 1'b0;
    hs_mask  = 8'h00;
    case (mode_ff)
      HPP_MODE1_IN: begin
        a_in_en = 1'b1;
        b_in_en = 1'b1;
        hs_mask = 8'h3F;
      end
      HPP_MODE1_OUT: begin
        a_out_en = 1'b1;
        b_out_en = 1'b1;
        hs_mask  = 8'hCF;
      end
      HPP_MODE2: begin
        a_in_en  = 1'b1;
        a_out_en = 1'b1;
        hs_mask  = 8'hF8;
      end
      default: begin
        hs_mask = 8'h00;
      end
    endcase
  end

  // Handshake inputs picked from their mode positions
  assign a_stb_n = i_pc_in[4];
  assign a_ack_n = i_pc_in[6];
  assign b_stb_n = i_pc_in[2];
  assign b_ack_n = i_pc_in[2];
  assign a_rd    = rd && hit(req.paddr, `HPP_OFF_PA);
  assign b_rd    = rd && hit(req.paddr, `HPP_OFF_PB);
  assign a_wr    = wr && hit(req.paddr, `HPP_OFF_PA);
  assign b_wr    = wr && hit(req.paddr, `HPP_OFF_PB);

  hpp_group u_grp_a (
    .i_sys_clk  (i_sys_clk),
    .i_rst_n    (rst_n),
    .i_in_en    (a_in_en),
    .i_out_en   (a_out_en),
    .i_stb_n    (a_stb_n),
    .i_ack_n    (a_ack_n),
    .i_pin_data (i_pa_in),
    .i_host_rd  (a_rd),
    .i_host_wr  (a_wr),
    .o_in_data  (a_data),
    .o_ibf      (a_ibf),
    .o_obf_n    (a_obf_n),
    .o_ev_in    (a_ev_in),
    .o_ev_out   (a_ev_out)
  );

  hpp_group u_grp_b (
    .i_sys_clk  (i_sys_clk),
    .i_rst_n    (rst_n),
    .i_in_en    (b_in_en),
    .i_out_en   (b_out_en),
    .i_stb_n    (b_stb_n),
    .i_ack_n    (b_ack_n),
    .i_pin_data (i_pb_in),
    .i_host_rd  (b_rd),
    .i_host_wr  (b_wr),
    .o_in_data  (b_data),
    .o_ibf      (b_ibf),
    .o_obf_n    (b_obf_n),
    .o_ev_in    (b_ev_in),
    .o_ev_out   (b_ev_out)
  );

  // ----------------------------------------
  // Events and service requests
  // ----------------------------------------
  wire logic [`HPP_NUM_EV-1:0] ev = {b_ev_out, b_ev_in, a_ev_out, a_ev_in};
  // Write-one-to-clear strobe for the status bits
  wire logic [`HPP_NUM_EV-1:0] stat_clr =
    (wr && hit(req.paddr, `HPP_OFF_STAT)) ? req.pwdata[`HPP_NUM_EV-1:0] : 4'h0;

  // Sticky status, set beats clear per bit
  genvar gi;
  generate
    for (gi = 0; gi < `HPP_NUM_EV; gi++) begin : g_stat
      always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          stat_ff[gi] <= 1'b0;
        end else if (ev[gi]) begin
          stat_ff[gi] <= 1'b1;
        end else if (stat_clr[gi]) begin
          stat_ff[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Request pins: pending event of this group, gated by its enable
  // Levels, not pulses: a request stays up until software clears it
  assign service_request_a = ien_ff[0] && (stat_ff[`HPP_EV_IN_A] || stat_ff[`HPP_EV_OUT_A]);
  assign service_request_b = ien_ff[1] && (stat_ff[`HPP_EV_IN_B] || stat_ff[`HPP_EV_OUT_B]);
  assign o_irq  = |(stat_ff & imask_ff) && (|ien_ff);

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  logic [7:0] hs_val;   // Handshake role values on port C
  always_comb begin
    hs_val = 8'h00;
    case (mode_ff)
      HPP_MODE1_IN: hs_val = {2'b00, a_ibf, 1'b0, service_request_a, 1'b0, b_ibf, service_request_b};
      HPP_MODE1_OUT: hs_val = {a_obf_n, 1'b0, 2'b00, service_request_a, 1'b0, b_obf_n, service_request_b};
      HPP_MODE2: hs_val = {a_obf_n, 1'b0, a_ibf, 1'b0, service_request_a, 3'b000};
      default: hs_val = 8'h00;
    endcase
  end
  // Handshake outputs are the roles that the device drives
  wire logic [7:0] hs_drv_m = (mode_ff == HPP_MODE2) ? 8'hA8 : hs_mask & 8'hAB;
  wire logic [7:0] pc_gp_oe = {{4{dir_ff[3]}}, {4{dir_ff[2]}}};

  // Handshake inputs always float; plain lines follow the direction bits
  assign o_pc_out  = (hs_val & hs_drv_m) | (pc_ff & ~hs_mask);
  assign o_pc_oe_n = ~(hs_drv_m | (pc_gp_oe & ~hs_mask));
  // Mode 2 port A is driven only while the partner acknowledges
  assign o_pa_out  = pa_ff;
  assign o_pa_oe_n = (mode_ff == HPP_MODE2) ? {8{a_ack_n}} :
                     (mode_ff == HPP_MODE1_IN) ? 8'hFF : {8{~dir_ff[0]}};
  assign o_pb_out  = pb_ff;
  assign o_pb_oe_n = (mode_ff == HPP_MODE1_IN) ? 8'hFF : {8{~dir_ff[1]}};

  // ----------------------------------------
  // APB read path
  // ----------------------------------------
  always_comb begin
    o_prdata = 32'h0000_0000;
    if (hit(req.paddr, `HPP_OFF_MODE)) begin
      o_prdata = {30'h0, mode_ff};
    end else if (hit(req.paddr, `HPP_OFF_PA)) begin
      o_prdata = {24'h0, a_in_en ? a_data : i_pa_in};
    end else if (hit(req.paddr, `HPP_OFF_PB)) begin
      o_prdata = {24'h0, b_in_en ? b_data : i_pb_in};
    end else if (hit(req.paddr, `HPP_OFF_PC)) begin
      o_prdata = {24'h0, i_pc_in};
    end else if (hit(req.paddr, `HPP_OFF_DIR)) begin
      o_prdata = {28'h0, dir_ff};
    end else if (hit(req.paddr, `HPP_OFF_IEN)) begin
      o_prdata = {30'h0, ien_ff};
    end else if (hit(req.paddr, `HPP_OFF_STAT)) begin
      o_prdata = {28'h0, stat_ff};
    end else if (hit(req.paddr, `HPP_OFF_IMASK)) begin
      o_prdata = {28'h0, imask_ff};
    end else if (hit(req.paddr, `HPP_OFF_HS)) begin
      o_prdata = {26'h0, service_request_b, service_request_a, b_obf_n, b_ibf, a_obf_n, a_ibf};
    end
  end

  // Zero-wait slave; unmapped addresses flag an error
  assign o_pready  = 1'b1;
  assign o_pslverr = acc && !(hit(req.paddr, `HPP_OFF_MODE) || hit(req.paddr, `HPP_OFF_PA) ||
                     hit(req.paddr, `HPP_OFF_PB) || hit(req.paddr, `HPP_OFF_PC) ||
                     hit(req.paddr, `HPP_OFF_DIR) || hit(req.paddr, `HPP_OFF_IEN) ||
                     hit(req.paddr, `HPP_OFF_STAT) || hit(req.paddr, `HPP_OFF_IMASK) ||
                     hit(req.paddr, `HPP_OFF_HS));

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Checks look at the pins where they can, so a wrong mux still shows
  chk_mode0_nohs: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (mode_ff == HPP_MODE0) |-> (o_pc_out == pc_ff && o_pc_oe_n == ~pc_gp_oe))
    else $error("mode 0 has handshake lines");
  chk_m1in_map: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (mode_ff == HPP_MODE1_IN) |-> (o_pc_out[5] == a_ibf && o_pc_out[1] == b_ibf))
    else $error("mode 1 input map wrong");
  chk_m1out_map: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (mode_ff == HPP_MODE1_OUT) |-> (o_pc_out[7] == a_obf_n && !o_pc_oe_n[7]))
    else $error("mode 1 output map wrong");
  chk_m2_map: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (mode_ff == HPP_MODE2) |-> (o_pc_out[3] == service_request_a && o_pc_oe_n[6] && o_pc_oe_n[4]))
    else $error("mode 2 map wrong");
  chk_stb_capture: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (a_in_en && !a_stb_n && !a_ibf && a_in_en) |=> (a_ibf && a_data == $past(i_pa_in)))
    else $error("strobe did not capture");
  chk_wr_obf: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (a_out_en && a_wr) |=> !a_obf_n) else $error("write did not set output full");
  chk_ien_gate: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (mode_ff != HPP_MODE0 && !ien_ff[0]) |-> !o_pc_out[3])
    else $error("request without enable");
  chk_rd_clear: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (a_ibf && a_rd && a_stb_n) |=> !a_ibf) else $error("read did not clear input full");
  chk_ack_free: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (a_out_en && !a_ack_n && !a_wr) |=> a_obf_n) else $error("acknowledge did not free");
  chk_m1in_req: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (mode_ff == HPP_MODE1_IN) |-> (o_pc_out[3] == service_request_a && o_pc_out[0] == service_request_b &&
      o_pc_oe_n[4] && o_pc_oe_n[2])) else $error("mode 1 input request lines wrong");
  chk_b_capture: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (b_in_en && !b_stb_n && !b_ibf) |=> (b_ibf && b_data == $past(i_pb_in)))
    else $error("group B strobe did not capture");
  chk_req_level: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (mode_ff != HPP_MODE0 && ien_ff[0] && stat_ff[`HPP_EV_OUT_A]) |-> o_pc_out[3])
    else $error("service request A not raised");
  chk_ack_event: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (a_out_en && !a_ack_n) ##1 (a_out_en && a_ack_n) |=> stat_ff[`HPP_EV_OUT_A])
    else $error("acknowledge end did not post event");
  chk_in_paced: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    (!a_ibf && a_stb_n) |=> !a_ibf) else $error("input full rose without strobe");
endmodule : hpp_port

//--- logic/hpp_cfg.svh
`ifndef HPP_CFG_SVH
`define HPP_CFG_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define HPP_OFF_MODE    12'h000
`define HPP_OFF_PA      12'h004
`define HPP_OFF_PB      12'h008
`define HPP_OFF_PC      12'h00C
`define HPP_OFF_DIR     12'h010
`define HPP_OFF_IEN     12'h014
`define HPP_OFF_STAT    12'h018
`define HPP_OFF_IMASK   12'h01C
`define HPP_OFF_HS      12'h020
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define HPP_MODE_W      2
`define HPP_MODE_RST    2'h0
`define HPP_DIR_RST     4'h0
`define HPP_EV_IN_A     0
`define HPP_EV_OUT_A    1
`define HPP_EV_IN_B     2
`define HPP_EV_OUT_B    3
`define HPP_NUM_EV      4
`endif

//--- logic/hpp_pkg.sv
package hpp_pkg;
  // Port C line roles per mode
  typedef enum logic [1:0] {
    HPP_MODE0,
    HPP_MODE1_IN,
    HPP_MODE1_OUT,
    HPP_MODE2
  } hpp_mode_type;

  // APB request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } hpp_apb_req_type;

  // One group's handshake pin levels
  typedef struct packed {
    logic stb_n;
    logic ack_n;
  } hpp_hs_in_type;
endpackage : hpp_pkg

//--- logic/hpp_group.sv
`timescale 1ns/10ps
`include "hpp_cfg.svh"
// ----------------------------------------
// One handshake group: input and output latch pairs
// ----------------------------------------
module hpp_group
  import hpp_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_in_en,       // Input handshake active
  input  wire logic       i_out_en,      // Output handshake active
  input  wire logic       i_stb_n,       // input_load_strobe_n pin
  input  wire logic       i_ack_n,       // Acknowledge pin
  input  wire logic [7:0] i_pin_data,    // Data port pins
  input  wire logic       i_host_rd,     // Host read of data port
  input  wire logic       i_host_wr,     // Host write of data port
  output logic      [7:0] o_in_data,     // Latched input byte
  output logic            o_ibf,         // input_latch_full
  output logic            o_obf_n,       // output_latch_full_n
  output logic            o_ev_in,       // Input byte arrived pulse
  output logic            o_ev_out       // Output byte taken pulse
);
  logic [7:0] in_data_ff;   // Input latch
  logic       ibf_ff;       // Latch holds an unread byte
  logic       obf_n_ff;     // Low while output byte pending
  logic       ack_seen_ff;  // Acknowledge held low last cycle

  // ----------------------------------------
  // Input latch
  // ----------------------------------------
  // Capture only when latch empty, so an unread byte is never lost
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in_data_ff <= 8'h00;
    end else if (i_in_en && !i_stb_n && !ibf_ff) begin
      in_data_ff <= i_pin_data;
    end
  end

  // Full flag: strobe sets, host read clears; set wins
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ibf_ff <= 1'b0;
    end else if (i_in_en && !i_stb_n && !ibf_ff) begin
      ibf_ff <= 1'b1;
    end else if (i_host_rd || !i_in_en) begin
      ibf_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Output latch flag
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      obf_n_ff <= 1'b1;
    end else if (i_out_en && i_host_wr) begin
      obf_n_ff <= 1'b0;
    end else if (!i_ack_n || !i_out_en) begin
      obf_n_ff <= 1'b1;
    end
  end

  // Track acknowledge to find its trailing edge
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_seen_ff <= 1'b0;
    end else begin
      ack_seen_ff <= i_out_en && !i_ack_n;
    end
  end

  assign o_in_data = in_data_ff;
  assign o_ibf     = ibf_ff;
  assign o_obf_n   = obf_n_ff;
  // Input event: byte just captured
  assign o_ev_in   = i_in_en && !i_stb_n && !ibf_ff;
  // Output event: acknowledge has ended
  assign o_ev_out  = ack_seen_ff && i_ack_n;
endmodule : hpp_group

//--- bench/hpp_ext_dev.sv
`timescale 1ns/10ps
// ----------------------------------------
// Far-side device: strobes bytes in, acknowledges bytes out
// ----------------------------------------
module hpp_ext_dev
  import hpp_pkg::*;
(
  input  wire logic         i_sys_clk,
  input  wire hpp_mode_type i_mode,     // Mode the port is set to
  input  wire logic         i_send_a,   // Start a group A strobe
  input  wire logic         i_send_b,   // Start a group B strobe
  input  wire logic   [7:0] i_byte,     // Byte to strobe in
  input  wire logic   [3:0] i_ack_dly,  // Cycles before acknowledging
  input  wire logic   [7:0] i_pa,       // Resolved port A wire
  input  wire logic   [7:0] i_pb,       // Resolved port B wire
  input  wire logic   [7:0] i_pc,       // Resolved port C wire
  output logic        [7:0] o_pa,       // Our port A levels
  output logic        [7:0] o_pb,       // Our port B levels
  output logic        [7:0] o_pc,       // Our port C levels
  output logic        [7:0] o_got_a,    // Byte taken by last ack A
  output logic        [7:0] o_got_b     // Byte taken by last ack B
);
  logic [1:0] sa_ff = 2'h0;  // Strobe A low counter
  logic [1:0] sb_ff = 2'h0;  // Strobe B low counter
  logic [4:0] ka_ff = 5'h0;  // Ack A wait-and-hold timer
  logic [4:0] kb_ff = 5'h0;  // Ack B wait-and-hold timer
  logic [7:0] da_ff = 8'h0;  // Byte on A
  logic [7:0] db_ff = 8'h0;  // Byte on B
  logic       tog_ff = 1'b0; // Free lines change every cycle
  logic       stb_a_n, stb_b_n, ack_a_n, ack_b_n, obf_a_n, obf_b_n;

  assign stb_a_n = (sa_ff == 2'h0);
  assign stb_b_n = (sb_ff == 2'h0);
  assign ack_a_n = !(ka_ff inside {5'h1, 5'h2});
  assign ack_b_n = !(kb_ff inside {5'h1, 5'h2});
  assign obf_a_n = (i_mode inside {HPP_MODE1_OUT, HPP_MODE2}) ? i_pc[7] : 1'b1;
  assign obf_b_n = (i_mode == HPP_MODE1_OUT) ? i_pc[1] : 1'b1;
  // Released data shows the inverse, so no stale byte can pass
  assign o_pa = (sa_ff != 2'h0) ? da_ff : ~da_ff;
  assign o_pb = (sb_ff != 2'h0) ? db_ff : ~db_ff;

  // Strobe and acknowledge lines idle high in every mode, so a mode
  // change on either side shows no false edge; other lines toggle
  always_comb begin
    o_pc    = {8{tog_ff}};
    o_pc[6] = ack_a_n;
    o_pc[4] = stb_a_n;
    o_pc[2] = stb_b_n && ack_b_n;
  end

  // Strobe two cycles; ack after a delay, taking the byte meanwhile
  always @(posedge i_sys_clk) begin
    tog_ff <= ~tog_ff;
    if (i_send_a) begin
      sa_ff <= 2'h2;
      da_ff <= i_byte;
    end else if (sa_ff != 2'h0) begin
      sa_ff <= sa_ff - 2'h1;
    end
    if (i_send_b) begin
      sb_ff <= 2'h2;
      db_ff <= i_byte;
    end else if (sb_ff != 2'h0) begin
      sb_ff <= sb_ff - 2'h1;
    end
    if (ka_ff != 5'h0) begin
      ka_ff <= ka_ff - 5'h1;
      if (!ack_a_n) o_got_a <= i_pa;
    end else if (!obf_a_n) begin
      ka_ff <= {1'b0, i_ack_dly} + 5'h2;
    end
    if (kb_ff != 5'h0) begin
      kb_ff <= kb_ff - 5'h1;
      if (!ack_b_n) o_got_b <= i_pb;
    end else if (!obf_b_n) begin
      kb_ff <= {1'b0, i_ack_dly} + 5'h2;
    end
  end
endmodule : hpp_ext_dev

//--- bench/testbench.sv
`timescale 1ns/10ps
`include "hpp_cfg.svh"
module testbench
  import hpp_pkg::*;
;
  logic         sys_clk = 1'b0;        // 100 MHz
  logic         rst_n;                 // Active-low reset
  logic         psel, penable, pwrite; // APB controls
  logic  [11:0] paddr;
  logic  [31:0] pwdata, prdata;
  logic         pready, pslverr, irq;
  logic   [7:0] pa_out, pa_oe_n, pb_out, pb_oe_n, pc_out, pc_oe_n;
  logic   [7:0] ext_pa, ext_pb, ext_pc, pa_pin, pb_pin, pc_pin;
  logic   [7:0] got_a, got_b, send_byte;
  logic         send_a, send_b;
  logic   [3:0] ack_dly;
  hpp_mode_type mode;
  int           n_errors = 0;
  int           total_checks = 0;

  always #5 sys_clk = ~sys_clk;

  // Wire level: whoever enables wins, else the far side
  assign pa_pin = (pa_oe_n & ext_pa) | (~pa_oe_n & pa_out);
  assign pb_pin = (pb_oe_n & ext_pb) | (~pb_oe_n & pb_out);
  assign pc_pin = (pc_oe_n & ext_pc) | (~pc_oe_n & pc_out);

  hpp_port dut_u (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_pa_in(pa_pin),
    .o_pa_out(pa_out), .o_pa_oe_n(pa_oe_n), .i_pb_in(pb_pin), .o_pb_out(pb_out),
    .o_pb_oe_n(pb_oe_n), .i_pc_in(pc_pin), .o_pc_out(pc_out), .o_pc_oe_n(pc_oe_n),
    .o_irq(irq));

  hpp_ext_dev ext_u (.i_sys_clk(sys_clk), .i_mode(mode), .i_send_a(send_a),
    .i_send_b(send_b), .i_byte(send_byte), .i_ack_dly(ack_dly), .i_pa(pa_pin),
    .i_pb(pb_pin), .i_pc(pc_pin), .o_pa(ext_pa), .o_pb(ext_pb), .o_pc(ext_pc),
    .o_got_a(got_a), .o_got_b(got_b));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic close_out();
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // One APB transfer; idle edge after it so the next setup is clean
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_errors++;
      close_out();
    end
    @(posedge sys_clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, 32'h0);
  endtask : rd

  // Bounded wait for a port C line, then compare it
  task automatic wait_pin(input int idx, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pc_pin[idx] !== v && n < 50);
    chk(pc_pin[idx], v);
    if (n >= 50) close_out();
  endtask : wait_pin

  task automatic send(input int g, input logic [7:0] b);
    send_byte <= b;
    send_a <= (g == 0);
    send_b <= (g == 1);
    @(posedge sys_clk);
    send_a <= 1'b0;
    send_b <= 1'b0;
  endtask : send

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    logic        e;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {send_a, send_b, send_byte, ack_dly} = '0;
    mode = HPP_MODE0;
    rst_n = 1'b0;
    tick(10);
    rst_n <= 1'b1;
    tick(4);
    // Reset state and an unmapped place
    rd(`HPP_OFF_MODE, 32'h0);
    rd(`HPP_OFF_STAT, 32'h0);
    rd(`HPP_OFF_HS, 32'h0000000A);
    chk({pa_oe_n, pb_oe_n, pc_oe_n, 7'h0, irq}, 32'hFFFFFF00);
    apb(1'b0, 12'h100, 32'h0, r, e);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
    // Mode 0: two plain nibble groups
    wr(`HPP_OFF_DIR, 32'h5);
    wr(`HPP_OFF_PC, 32'hA5);
    wr(`HPP_OFF_PA, 32'h33);
    chk({pc_oe_n, pc_out[3:0], pa_oe_n, pa_out}, {8'hF0, 4'h5, 16'h0033});
    wr(`HPP_OFF_DIR, 32'h8);
    chk({pc_oe_n, pc_out[7:4]}, {8'h0F, 4'hA});
    // Mode 1 input on both groups, interrupt path
    mode <= HPP_MODE1_IN;
    wr(`HPP_OFF_DIR, 32'h0);
    wr(`HPP_OFF_MODE, 32'h1);
    wr(`HPP_OFF_IMASK, 32'hF);
    for (int g = 0; g < 2; g++) begin
      send(g, 8'h3C ^ g[7:0]);
      wait_pin(g ? 1 : 5, 1'b1);
      chk({pc_oe_n[g ? 1 : 5], pc_pin[g ? 0 : 3], irq}, 3'b000);
      send(g, 8'hC3);
      tick(6);
      rd(g ? `HPP_OFF_PB : `HPP_OFF_PA, 32'h3C ^ g);
      wait_pin(g ? 1 : 5, 1'b0);
      rd(`HPP_OFF_STAT, g ? 32'h4 : 32'h1);
      wr(`HPP_OFF_IEN, g ? 32'h2 : 32'h1);
      chk({pc_pin[g ? 0 : 3], irq}, 2'b11);
      wr(`HPP_OFF_IMASK, 32'h0);
      chk({pc_pin[g ? 0 : 3], irq}, 2'b10);
      wr(`HPP_OFF_IMASK, 32'hF);
      wr(`HPP_OFF_STAT, 32'hF);
      chk({pc_pin[g ? 0 : 3], irq}, 2'b00);
      wr(`HPP_OFF_IEN, 32'h0);
    end
    // Mode 1 output, slow then prompt acknowledge
    wr(`HPP_OFF_MODE, 32'h2);
    mode <= HPP_MODE1_OUT;
    wr(`HPP_OFF_DIR, 32'h3);
    wr(`HPP_OFF_IEN, 32'h3);
    for (int g = 0; g < 2; g++) begin
      ack_dly <= g ? 4'h1 : 4'h6;
      wr(g ? `HPP_OFF_PB : `HPP_OFF_PA, 32'h5A ^ g);
      wait_pin(g ? 1 : 7, 1'b0);
      chk(g ? {pb_oe_n, pb_out} : {pa_oe_n, pa_out}, 32'h5A ^ g);
      chk(pc_oe_n[5:4], 2'b11);
      wait_pin(g ? 1 : 7, 1'b1);
      wait_pin(g ? 0 : 3, 1'b1);
      chk(g ? got_b : got_a, 8'h5A ^ g);
      rd(`HPP_OFF_STAT, g ? 32'h8 : 32'h2);
      wr(`HPP_OFF_STAT, 32'hF);
    end
    // Mode 2: group A both ways, low three lines plain
    wr(`HPP_OFF_MODE, 32'h3);
    mode <= HPP_MODE2;
    wr(`HPP_OFF_DIR, 32'h4);
    chk(pc_oe_n[2:0], 3'b000);
    ack_dly <= 4'h4;
    wr(`HPP_OFF_PA, 32'h96);
    wait_pin(7, 1'b0);
    chk(pa_oe_n, 8'hFF);
    wait_pin(7, 1'b1);
    tick(3);
    chk({got_a, pa_oe_n}, 16'h96FF);
    wr(`HPP_OFF_STAT, 32'hF);
    send(0, 8'h69);
    wait_pin(5, 1'b1);
    chk({pc_pin[7], pc_pin[3]}, 2'b11);
    rd(`HPP_OFF_PA, 32'h69);
    wr(`HPP_OFF_STAT, 32'hF);
    chk({pc_pin[3], irq}, 2'b00);
    close_out();
  end
endmodule : testbench
